// [bsr_pkg.sv]
package bsr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_REASON  = 8'h08;
    localparam logic [7:0] OFS_DISABLE = 8'h0C;
    localparam logic [7:0] OFS_MASK    = 8'h10;
    localparam logic [7:0] OFS_LIMIT   = 8'h14;

    // Reason, disable and mask bit positions
    localparam int EV_PW_PARITY = 0;
    localparam int EV_TGT_ABORT = 1;
    localparam int EV_MST_ABORT = 2;
    localparam int EV_PW_RETRY  = 3;
    localparam int EV_DW_RETRY  = 4;
    localparam int EV_DR_RETRY  = 5;
    localparam int EV_TIMEOUT   = 6;
    localparam int EV_SEC_FWD   = 7;
    localparam int EV_COUNT     = 8;

    // Queue and retry counting
    localparam int NSLOT        = 4;
    localparam int CNT_W        = 25;
    localparam int RETRY_DFLT   = 16777216;

    // Values after reset
    localparam logic [7:0] RST_DISABLE = 8'h00;
    localparam logic [7:0] RST_MASK    = 8'h00;

    // Kind of a queued transaction
    typedef enum logic [1:0] {
        KIND_POSTED_WR,
        KIND_DELAYED_WR,
        KIND_DELAYED_RD
    } bsr_kind_t;

    // One queue slot as seen by the retry logic
    typedef struct packed {
        logic      retry;
        logic      done;
        bsr_kind_t kind;
    } bsr_slot_t;

    // Control bits of the command and bridge control registers
    typedef struct packed {
        logic timeout_serr_en;
        logic serr_fwd_en;
        logic bctl_parity_en;
        logic cmd_serr_en;
        logic cmd_parity_en;
    } bsr_ctrl_t;

    // Status flags
    typedef struct packed {
        logic received;
        logic signaled;
    } bsr_status_t;
endpackage

// [bsr_serr.sv]
`timescale 1ns/10ps
module bsr_serr
    import bsr_pkg::*;
#(
    parameter logic [CNT_W-1:0] RETRY_LIMIT = CNT_W'(RETRY_DFLT)
) (
    // Clock and reset
    input  logic             clk,
    input  logic             rst,
    // APB slave
    input  logic             psel,
    input  logic             penable,
    input  logic             pwrite,
    input  logic [7:0]       paddr,
    input  logic [31:0]      pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus pins
    input  logic             primary_parity_error_n,
    input  logic             secondary_parity_error_n,
    input  logic             secondary_system_error_n,
    output logic             primary_system_error_n,
    output logic             primary_system_error_oe,
    // Transaction context from the forwarding logic
    input  logic             pw_up_on_primary,
    input  logic             pw_down_on_secondary,
    input  logic             pw_up_seen_as_target,
    input  logic             pw_down_seen_as_target,
    input  logic             pw_target_abort,
    input  logic             pw_master_abort,
    input  logic             delayed_timeout,
    // Queue slots
    input  bsr_slot_t [NSLOT-1:0] slot,
    output logic [NSLOT-1:0] slot_discard,
    // Interrupt
    output logic             irq
);

    bsr_ctrl_t             ctrl;
    bsr_status_t           status;
    logic [EV_COUNT-1:0]   reason;
    logic [EV_COUNT-1:0]   disable_bits;
    logic [EV_COUNT-1:0]   irq_mask;
    logic [CNT_W-1:0]      limit;
    logic [CNT_W-1:0]      cnt [NSLOT];
    logic [NSLOT-1:0]      slot_hit;
    logic [EV_COUNT-1:0]   cause;
    logic [EV_COUNT-1:0]   fire;
    logic                  par_cause;
    logic                  sec_serr;
    logic                  wr_en;
    logic                  rd_en;
    logic [31:0]           next_prdata;
    logic                  bad_addr;

    // Bus handshake; one wait state keeps every answer registered
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && bad_addr;
        end
    end

    // Read mux; unmapped offsets read zero with an error
    always_comb begin
        next_prdata = 32'h0000_0000;
        bad_addr    = 1'b0;
        unique case (paddr)
            OFS_CTRL:    next_prdata = 32'(ctrl);
            OFS_STATUS:  next_prdata = 32'(status);
            OFS_REASON:  next_prdata = 32'(reason);
            OFS_DISABLE: next_prdata = 32'(disable_bits);
            OFS_MASK:    next_prdata = 32'(irq_mask);
            OFS_LIMIT:   next_prdata = 32'(limit);
            default:     bad_addr    = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    // Plain read-write configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl         <= '0;
            disable_bits <= RST_DISABLE;
            irq_mask     <= RST_MASK;
            limit        <= RETRY_LIMIT;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL) begin
                ctrl <= bsr_ctrl_t'(pwdata[4:0]);
            end
            if (paddr == OFS_DISABLE) begin
                // No disable for timeout or forwarding, those bits stay zero
                disable_bits <= {2'b00, pwdata[5:0]};
            end
            if (paddr == OFS_MASK) begin
                irq_mask <= pwdata[EV_COUNT-1:0];
            end
            if (paddr == OFS_LIMIT) begin
                // A zero limit would only match at the all-ones count, so it is kept at one
                limit <= (pwdata[CNT_W-1:0] == '0) ? CNT_W'(1) : pwdata[CNT_W-1:0];
            end
        end
    end

    // Retry counters, one per queue slot
    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
        assign slot_hit[i] = slot[i].retry && !slot[i].done && (cnt[i] == limit - CNT_W'(1));

        always_ff @(posedge clk) begin
            if (rst) begin
                cnt[i] <= '0;
            end else if (slot[i].done || slot_hit[i]) begin
                cnt[i] <= '0;
            end else if (slot[i].retry) begin
                cnt[i] <= cnt[i] + CNT_W'(1);
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                slot_discard[i] <= 1'b0;
            end else begin
                slot_discard[i] <= slot_hit[i];
            end
        end

        a_retry_limit: assert property (@(posedge clk) disable iff (rst)
            slot_discard[i] |-> $past(cnt[i]) == limit - CNT_W'(1))
            else $error("discard without counter at limit");
    end

    // Parity cause only from the target bus of a posted write
    assign par_cause = ctrl.cmd_parity_en && ctrl.bctl_parity_en
        && ((pw_up_on_primary && !primary_parity_error_n && !pw_up_seen_as_target)
        || (pw_down_on_secondary && !secondary_parity_error_n && !pw_down_seen_as_target));
    assign sec_serr = !secondary_system_error_n;

    // Raw causes by event; reads and delayed writes feed no parity term
    always_comb begin
        cause = '0;
        cause[EV_PW_PARITY] = par_cause;
        cause[EV_TGT_ABORT] = pw_target_abort;
        cause[EV_MST_ABORT] = pw_master_abort;
        for (int k = 0; k < NSLOT; k++) begin
            if (slot_hit[k] && slot[k].kind == KIND_POSTED_WR) begin
                cause[EV_PW_RETRY] = 1'b1;
            end
            if (slot_hit[k] && slot[k].kind == KIND_DELAYED_WR) begin
                cause[EV_DW_RETRY] = 1'b1;
            end
            if (slot_hit[k] && slot[k].kind == KIND_DELAYED_RD) begin
                cause[EV_DR_RETRY] = 1'b1;
            end
        end
        cause[EV_TIMEOUT] = delayed_timeout && ctrl.timeout_serr_en;
        cause[EV_SEC_FWD] = sec_serr && ctrl.serr_fwd_en;
    end

    // Every drive needs the command enable
    assign fire = ctrl.cmd_serr_en ? (cause & ~disable_bits) : '0;

    // Open-drain output: low level, enable pulses one cycle per event
    always_ff @(posedge clk) begin
        if (rst) begin
            primary_system_error_n  <= 1'b0;
            primary_system_error_oe <= 1'b0;
        end else begin
            primary_system_error_n  <= 1'b0;
            primary_system_error_oe <= |fire;
        end
    end

    // Reason flags, sticky, new events win over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            reason <= '0;
        end else if (wr_en && paddr == OFS_REASON) begin
            reason <= (reason & ~pwdata[EV_COUNT-1:0]) | fire;
        end else begin
            reason <= reason | fire;
        end
    end

    // Status flags, same set-over-clear rule
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else begin
            if (wr_en && paddr == OFS_STATUS) begin
                status.signaled <= (status.signaled && !pwdata[0]) || (|fire);
                status.received <= (status.received && !pwdata[1]) || sec_serr;
            end else begin
                status.signaled <= status.signaled || (|fire);
                status.received <= status.received || sec_serr;
            end
        end
    end

    // Interrupt follows stored flags, one cycle late
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(reason & irq_mask);
        end
    end

    // Checks
    sequence s_sec_req;
        !secondary_system_error_n && ctrl.serr_fwd_en && ctrl.cmd_serr_en;
    endsequence

    sequence s_drive;
        primary_system_error_oe && !primary_system_error_n;
    endsequence

    a_serr_gated: assert property (@(posedge clk) disable iff (rst)
        primary_system_error_oe |-> $past(ctrl.cmd_serr_en))
        else $error("system error driven while disabled");

    a_signaled_flag: assert property (@(posedge clk) disable iff (rst)
        s_drive |-> status.signaled)
        else $error("drive without signaled flag");

    a_sec_forward: assert property (@(posedge clk) disable iff (rst)
        s_sec_req |=> s_drive ##0 reason[EV_SEC_FWD])
        else $error("secondary error not forwarded");

    a_received_flag: assert property (@(posedge clk) disable iff (rst)
        !secondary_system_error_n |=> status.received)
        else $error("received flag not set");

    a_parity_gate: assert property (@(posedge clk) disable iff (rst)
        $rose(reason[EV_PW_PARITY]) |-> $past(ctrl.cmd_parity_en && ctrl.bctl_parity_en))
        else $error("parity event with response disabled");

    a_parity_report: assert property (@(posedge clk) disable iff (rst)
        (pw_down_on_secondary && !secondary_parity_error_n && !pw_down_seen_as_target
         && ctrl.cmd_parity_en && ctrl.bctl_parity_en && ctrl.cmd_serr_en
         && !disable_bits[EV_PW_PARITY]) |=> s_drive ##0 reason[EV_PW_PARITY])
        else $error("posted write parity not reported");

    a_target_seen: assert property (@(posedge clk) disable iff (rst)
        (pw_up_on_primary && pw_up_seen_as_target && !pw_down_on_secondary
         && !reason[EV_PW_PARITY]) |=> !reason[EV_PW_PARITY])
        else $error("parity reported though seen as target");

    a_event_disable: assert property (@(posedge clk) disable iff (rst)
        (pw_target_abort && disable_bits[EV_TGT_ABORT] && !reason[EV_TGT_ABORT])
        |=> !reason[EV_TGT_ABORT])
        else $error("disabled event recorded");

    a_timeout_gate: assert property (@(posedge clk) disable iff (rst)
        (delayed_timeout && ctrl.timeout_serr_en && ctrl.cmd_serr_en) |=> s_drive ##0 reason[EV_TIMEOUT])
        else $error("timeout not reported");

    a_reason_hold: assert property (@(posedge clk) disable iff (rst)
        (reason[EV_MST_ABORT] && !(wr_en && paddr == OFS_REASON)) |=> reason[EV_MST_ABORT])
        else $error("reason flag lost");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        ##1 irq == $past(|(reason & irq_mask)))
        else $error("interrupt level wrong");

endmodule

// [bsr_agent.sv]
`timescale 1ns/10ps
// Far-side PCI agents: error pins, transaction context and queue slots
module bsr_agent
    import bsr_pkg::*;
(
    // Clock
    input  wire logic                 clk,
    // Error pins, pulled up while released
    output logic                      primary_parity_error_n,
    output logic                      secondary_parity_error_n,
    output logic                      secondary_system_error_n,
    // Context lines and retry or done pulses
    output logic [6:0]                ctx,
    output logic [4*NSLOT-1:0]        slot
);
    // Idle: pins at pull-up level, no context
    initial begin
        {primary_parity_error_n, secondary_parity_error_n, secondary_system_error_n} = 3'b111;
        ctx  = '0;
        slot = '0;
    end

    // One-cycle event; pins go back to the pull-up level afterwards
    task automatic pulse(input logic [2:0] pins_n, input logic [6:0] c, input logic [4*NSLOT-1:0] s);
        @(posedge clk);
        {primary_parity_error_n, secondary_parity_error_n, secondary_system_error_n} <= pins_n;
        ctx  <= c;
        slot <= s;
        @(posedge clk);
        {primary_parity_error_n, secondary_parity_error_n, secondary_system_error_n} <= 3'b111;
        ctx  <= '0;
        slot <= '0;
    endtask
endmodule

// [bsr_serr_test.sv]
`timescale 1ns/10ps
module bsr_serr_test
    import bsr_pkg::*;
;
    localparam int LIM = 4;
    logic               clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]         paddr = '0;
    logic [31:0]        pwdata = '0, prdata, r;
    logic               pready, pslverr, ppe_n, spe_n, sse_n, se_o, se_oe, irq, e;
    logic [6:0]         ctx;
    logic [4*NSLOT-1:0] slot;
    logic [NSLOT-1:0]   disc;
    int                 errors = 0, cmp_count = 0;

    // Short retry limit keeps the run brief
    bsr_serr #(.RETRY_LIMIT(CNT_W'(LIM))) i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_parity_error_n(ppe_n), .secondary_parity_error_n(spe_n),
        .secondary_system_error_n(sse_n), .primary_system_error_n(se_o),
        .primary_system_error_oe(se_oe), .pw_up_on_primary(ctx[6]), .pw_down_on_secondary(ctx[5]),
        .pw_up_seen_as_target(ctx[4]), .pw_down_seen_as_target(ctx[3]), .pw_target_abort(ctx[2]),
        .pw_master_abort(ctx[1]), .delayed_timeout(ctx[0]), .slot(slot), .slot_discard(disc), .irq(irq));
    bsr_agent i_agent (.clk(clk), .primary_parity_error_n(ppe_n), .secondary_parity_error_n(spe_n),
        .secondary_system_error_n(sse_n), .ctx(ctx), .slot(slot));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask

    // Slot vector with one slot active: {retry, done, kind}
    function automatic logic [4*NSLOT-1:0] mk(input int i, input logic [1:0] k, input logic rt, input logic dn);
        logic [4*NSLOT-1:0] v;
        v = '0;
        v[i*4 +: 4] = {rt, dn, k};
        return v;
    endfunction

    // Set control, raise one event, judge pin, discard, reason, status; then clear flags
    task automatic ev(input logic [7:0] c, input logic [2:0] p, input logic [6:0] x, input logic [15:0] s,
                      input logic oe, input logic [3:0] d, input logic [7:0] rs, input logic [1:0] st);
        apb(1, OFS_CTRL, 32'(c));
        i_agent.pulse(p, x, s);
        // Pin and discard pulses stand only in the cycle after the event edge
        #1;
        chk(32'({se_o, se_oe, disc}), 32'({1'b0, oe, d}));
        @(posedge clk);
        #1;
        chk(32'({se_oe, disc}), 32'h0000_0000);
        apb(0, OFS_REASON, '0);
        chk(r, 32'(rs));
        apb(0, OFS_STATUS, '0);
        chk(r, 32'(st));
        apb(1, OFS_REASON, 32'h0000_00ff);
        apb(1, OFS_STATUS, 32'h0000_0003);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            apb(0, 8'(i * 4), '0);
            chk(r, (i == 5) ? 32'(LIM) : '0);
        end
        apb(0, 8'h18, '0);
        chk({r[30:0], e}, 32'h0000_0001);
        // Zero limit is kept at one; bits above the counter width read zero
        apb(1, OFS_LIMIT, 32'h0000_0000);
        apb(0, OFS_LIMIT, '0);
        chk(r, 32'h0000_0001);
        apb(1, OFS_LIMIT, 32'hffff_ffff);
        apb(0, OFS_LIMIT, '0);
        chk(r, 32'h01ff_ffff);
        apb(1, OFS_LIMIT, 32'(LIM));
        $display("test registers done");
    endtask

    task automatic t_fwd();
        ev(8'h08, 3'b110, 7'h00, '0, 0, 0, 8'h00, 2'b10);
        ev(8'h0a, 3'b110, 7'h00, '0, 1, 0, 8'h80, 2'b11);
        apb(1, OFS_MASK, 32'h0000_0080);
        i_agent.pulse(3'b110, 7'h00, '0);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 1);
        apb(1, OFS_REASON, 32'h0000_0080);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 0);
        apb(1, OFS_MASK, '0);
        apb(1, OFS_STATUS, 32'h0000_0003);
        $display("test forward done");
    endtask

    task automatic t_parity();
        ev(8'h1f, 3'b011, 7'h40, '0, 1, 0, 8'h01, 2'b01);
        ev(8'h1f, 3'b101, 7'h20, '0, 1, 0, 8'h01, 2'b01);
        ev(8'h1f, 3'b011, 7'h50, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1f, 3'b101, 7'h28, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1b, 3'b011, 7'h40, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1e, 3'b101, 7'h20, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1f, 3'b101, 7'h40, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1f, 3'b011, 7'h20, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h1d, 3'b011, 7'h40, '0, 0, 0, 8'h00, 2'b00);
        $display("test parity done");
    endtask

    task automatic t_abort();
        ev(8'h02, 3'b111, 7'h04, '0, 1, 0, 8'h02, 2'b01);
        ev(8'h02, 3'b111, 7'h02, '0, 1, 0, 8'h04, 2'b01);
        apb(1, OFS_DISABLE, 32'h0000_0002);
        ev(8'h02, 3'b111, 7'h04, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h02, 3'b111, 7'h02, '0, 1, 0, 8'h04, 2'b01);
        apb(1, OFS_DISABLE, 32'h0000_00ff);
        apb(0, OFS_DISABLE, '0);
        chk(r, 32'h0000_003f);
        ev(8'h02, 3'b111, 7'h01, '0, 0, 0, 8'h00, 2'b00);
        ev(8'h12, 3'b111, 7'h01, '0, 1, 0, 8'h40, 2'b01);
        apb(1, OFS_DISABLE, '0);
        $display("test abort and timeout done");
    endtask

    // Limit-th retry discards; a done in between restarts the count
    task automatic t_retry();
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < LIM; j++) begin
                ev(8'h02, 3'b111, 7'h00, mk(k, 2'(k), 1, 0), j == LIM - 1, (j == LIM - 1) ? 4'(1 << k) : 4'h0,
                   (j == LIM - 1) ? 8'(1 << (3 + k)) : 8'h00, (j == LIM - 1) ? 2'b01 : 2'b00);
            end
        end
        for (int j = 0; j < 8; j++) begin
            ev(8'h02, 3'b111, 7'h00, mk(3, 2'b00, j != 3, j == 3), j == 7, (j == 7) ? 4'h8 : 4'h0,
               (j == 7) ? 8'h08 : 8'h00, (j == 7) ? 2'b01 : 2'b00);
        end
        $display("test retry done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_regs();
        t_fwd();
        t_parity();
        t_abort();
        t_retry();
        conclude();
    end
endmodule
